//--- src/tacw_pkg.sv
// Purpose: Shared constants for the touch converter control word decoder.
// Assumes: Control word arrives MSB first, start bit included, 8 bits.
// Notes:   All field positions and counts, and the power field and pin reset values, live here.
// Notes on behaviour
// R01: First high input bit starts word, bit 7
// R02: Host spaces words 15 or 11 clocks
// R03: Bits 6..4 select channel and switches
// R04: Bit 3 picks 12-bit (0) or 8-bit
// R05: Bit 2 selects reference configuration
// R06: Bits 1..0 decode power and pen mode
// R07: Power field resets to upper 1, lower 0
// R08: Reference power independent of converter power
// R09: Field 00: reference off, pen enabled
// R10: Lower bit 0: converter off after conversion
// R11: Converter powers up instantly, no delay
// R12: Field 00: Y minus switch closed powered down
// R13: Fields 0x: no reference for differential
// R14: Field 01: reference off, converter always on
// R15: Field 10: reference on, converter sleeps
// R16: Field 11: all on, pen interrupt disabled
// R17: Converter wakes on fourth falling clock edge
// R18: Converter sleeps at twentieth falling edge; code sleeps at the sixteenth in 8-bit mode
// R19: Input ignored until a start bit
// R20: Reference bit 1 single-ended, 0 ratiometric
// R21: Power bits apply only when word completes
// R22: Start bit disables the pen interrupt
// R23: Shift MSB first, eighth bit ends word
package tacw_pkg;

    // Control word layout
    localparam int unsigned WORD_W     = 8;
    localparam int unsigned START_POS  = 7;
    localparam int unsigned CH_MSB     = 6;
    localparam int unsigned CH_LSB     = 4;
    localparam int unsigned RES_POS    = 3;
    localparam int unsigned REF_POS    = 2;
    localparam int unsigned PWR_MSB    = 1;
    localparam int unsigned PWR_LSB    = 0;

    // Word shadow value right after a start bit
    localparam logic [7:0] WORD_START  = 8'h80;

    // Power field encodings and reset value
    localparam logic [1:0] PWR_RESET   = 2'h2;
    localparam logic [1:0] PWR_FULL    = 2'h3;
    localparam logic [1:0] PWR_DEEP    = 2'h0;

    // Falling serial clock edge counts after the start bit
    localparam int unsigned CNT_W      = 5;
    localparam logic [4:0] FALL_ADC_UP = 5'h04;
    localparam logic [4:0] FALL_DONE   = 5'h08;
    // Conversion length in falling edges after the word completes
    localparam logic [4:0] CONV_12B    = 5'h0c;
    localparam logic [4:0] CONV_8B     = 5'h08;

    // Synchroniser lanes
    localparam int unsigned SYNC_W     = 4;
    // Pin levels held in reset: {touch, cs_n, din, sclk}; deselected
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 4'h4;

    // Word reception states
    typedef enum logic [0:0] {
        TACW_WAIT_START,
        TACW_SHIFT_WORD
    } tacw_state_t;

endpackage : tacw_pkg

//--- src/tacw_sync.sv
// Purpose: Two flip-flop synchroniser for pins from outside clk_sys_i.
// Assumes: Each lane is an independent level; no bus coherency needed.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ns
module tacw_sync #(
    parameter int unsigned W = 1               // Lane count
) (
    input  wire logic         clk_sys_i,       // System clock
    input  wire logic         resetn_i,        // Sync reset, active low
    input  wire logic [W-1:0] async_i,         // Raw pin levels
    input  wire logic [W-1:0] reset_val_i,     // Idle levels during reset
    output logic      [W-1:0] sync_o           // Synchronised levels
);

    logic [W-1:0] meta_reg;                    // First stage
    logic [W-1:0] stab_reg;                    // Second stage

    // Plain two-stage chain; reset loads the pins' idle levels
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            meta_reg <= reset_val_i;
            stab_reg <= reset_val_i;
        end else begin
            meta_reg <= async_i;
            stab_reg <= meta_reg;
        end
    end

    assign sync_o = stab_reg;

endmodule // tacw_sync

//--- src/tacw_ctrl.sv
// Purpose: Control word decoder and power management of a touch converter.
// Assumes: Serial clock is slow (400 ns) against clk_sys_i (50 ns).
// Notes:   Serial pins pass tacw_sync; edges found on the system clock.
`timescale 1ns/1ns
module tacw_ctrl
    import tacw_pkg::*;
(
    input  wire logic       clk_sys_i,         // System clock, 20 MHz
    input  wire logic       resetn_i,          // Sync reset, active low
    input  wire logic       serial_clock_i,    // Serial clock pin
    input  wire logic       serial_din_i,      // Serial data input pin
    input  wire logic       cs_n_i,            // Chip select, active low
    input  wire logic       pen_touch_i,       // Touch detected, high
    output logic [2:0]      channel_select_o,  // Channel selector bits
    output logic            res_8bit_o,        // 1 = 8-bit conversion
    output logic            reference_select_o,// 1 single, 0 ratiometric
    output logic [1:0]      power_field_o,     // Committed power field
    output logic            ref_power_o,       // Internal reference on
    output logic            adc_power_o,       // Converter powered
    output logic            conv_active_o,     // Conversion in progress
    output logic            yminus_switch_o,   // Y minus switch closed
    output logic            touch_irq_n_o,     // Open-drain data, low
    output logic            touch_irq_n_oe_o   // Pulls touch_irq_n low
);
    import tacw_pkg::*;

    // Synchronised pins
    logic [SYNC_W-1:0] sync_raw;
    logic              sclk_s;                 // Serial clock level
    logic              din_s;                  // Serial data level
    logic              cs_n_s;                 // Chip select level
    logic              touch_s;                // Touch detect level

    // Reset holds idle levels so no false select or edge follows reset
    tacw_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .async_i     ({pen_touch_i, cs_n_i, serial_din_i, serial_clock_i}),
        .reset_val_i (SYNC_IDLE),
        .sync_o      (sync_raw)
    );

    assign sclk_s  = sync_raw[0];
    assign din_s   = sync_raw[1];
    assign cs_n_s  = sync_raw[2];
    assign touch_s = sync_raw[3];

    // State registers and their next values
    tacw_state_t      state_reg,  state_next;  // Word reception state
    logic             sclk_d_reg, sclk_d_next; // Last serial clock level
    logic             cs_d_reg,   cs_d_next;   // Last chip select level
    logic [7:0]       word_reg,   word_next;   // Word shadow
    logic [CNT_W-1:0] fall_reg,   fall_next;   // Falls since start
    logic [CNT_W-1:0] conv_reg,   conv_next;   // Falls in conversion
    logic             convon_reg, convon_next; // Conversion running
    logic             res8c_reg,  res8c_next;  // Resolution of conversion
    logic [1:0]       pwr_reg,    pwr_next;    // Committed power field
    logic             adcup_reg,  adcup_next;  // Converter awake
    logic             pen_en_reg, pen_en_next; // Pen interrupt armed
    logic             pull_reg,   pull_next;   // Open-drain pull active
    logic             ref_reg,    ref_next;    // Reference power
    logic             adc_reg,    adc_next;    // Converter power output
    logic             ymin_reg,   ymin_next;   // Y minus switch

    // Edge and event strobes, and the slot of the incoming bit
    logic             sclk_rise;               // Serial clock rising
    logic             sclk_fall;               // Serial clock falling
    logic             cs_rise;                 // Chip select released
    logic             start_hit;               // Start bit recognised
    logic             word_done;               // Eighth bit complete
    logic             conv_end;                // Conversion finished
    logic [2:0]       bit_pos;                 // Slot of incoming bit

    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign cs_rise   = cs_n_s & ~cs_d_reg;

    // Next-state logic for reception, conversion and the power field
    always_comb begin
        state_next  = state_reg;
        sclk_d_next = sclk_s;
        cs_d_next   = cs_n_s;
        word_next   = word_reg;
        fall_next   = fall_reg;
        conv_next   = conv_reg;
        convon_next = convon_reg;
        res8c_next  = res8c_reg;
        pwr_next    = pwr_reg;
        adcup_next  = adcup_reg;
        pen_en_next = pen_en_reg;
        start_hit   = 1'b0;
        word_done   = 1'b0;
        conv_end    = 1'b0;
        bit_pos     = 3'(START_POS - int'(fall_reg));

        if (cs_n_s) begin
            // Deselected: word abandoned, converter may sleep early
            state_next = TACW_WAIT_START;
            if (convon_reg) begin
                convon_next = 1'b0;
                pen_en_next = (pwr_reg != PWR_FULL);  // R16
            end
            if (!pwr_reg[PWR_LSB]) begin
                adcup_next = 1'b0;                     // R10
            end
        end else begin
            // Running conversion counts its own falling edges
            if (convon_reg && sclk_fall) begin
                conv_next = CNT_W'(conv_reg + 1'b1);
                if (conv_next == (res8c_reg ? CONV_8B : CONV_12B)) begin
                    conv_end    = 1'b1;
                    convon_next = 1'b0;
                    // Sleep unless a new word already woke us
                    if (!pwr_reg[PWR_LSB] &&
                        state_reg == TACW_WAIT_START) begin
                        adcup_next = 1'b0;             // R18
                    end
                    // Rearm only when no new word is arriving
                    if (state_reg == TACW_WAIT_START) begin
                        pen_en_next = (pwr_reg != PWR_FULL); // R16
                    end
                end
            end

            case (state_reg)
                TACW_WAIT_START: begin
                    // Zeros are ignored; first high bit opens a word
                    if (sclk_rise && din_s) begin       // R19
                        start_hit   = 1'b1;             // R01
                        state_next  = TACW_SHIFT_WORD;
                        word_next   = WORD_START;
                        fall_next   = '0;
                        pen_en_next = 1'b0;             // R22
                    end
                end
                TACW_SHIFT_WORD: begin
                    // Fields follow the shadow as each bit lands
                    if (sclk_rise && fall_reg < FALL_DONE) begin
                        word_next[bit_pos] = din_s;     // R23
                    end
                    if (sclk_fall) begin
                        fall_next = CNT_W'(fall_reg + 1'b1);
                        if (fall_next == FALL_ADC_UP) begin
                            adcup_next = 1'b1;          // R17 R11
                        end
                        if (fall_next == FALL_DONE) begin
                            word_done   = 1'b1;
                            state_next  = TACW_WAIT_START;
                            pwr_next    = word_reg[PWR_MSB:PWR_LSB]; // R21
                            res8c_next  = word_reg[RES_POS];         // R04
                            convon_next = 1'b1;
                            conv_next   = '0;
                        end
                    end
                end
                default: begin
                    state_next = TACW_WAIT_START;
                end
            endcase
        end
    end

    // Pin and power outputs follow the committed field
    always_comb begin
        pull_next = pen_en_next & touch_s;
        // Reference tracks only the upper bit, whatever the reference select bit
        ref_next  = pwr_next[PWR_MSB];                 // R08 R09 R13 R15
        // Lower bit keeps converter on for good
        adc_next  = adcup_next | pwr_next[PWR_LSB];    // R14 R16 R15
        // Deepest mode closes Y minus while asleep
        ymin_next = (pwr_next == PWR_DEEP) && !adc_next; // R12
    end

    // Registers only; reset values are constants
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state_reg  <= TACW_WAIT_START;
            sclk_d_reg <= 1'b0;
            cs_d_reg   <= 1'b1;
            word_reg   <= '0;
            fall_reg   <= '0;
            conv_reg   <= '0;
            convon_reg <= 1'b0;
            res8c_reg  <= 1'b0;
            pwr_reg    <= PWR_RESET;                   // R07
            adcup_reg  <= 1'b0;
            pen_en_reg <= 1'b1;
            pull_reg   <= 1'b0;
            ref_reg    <= PWR_RESET[PWR_MSB];
            adc_reg    <= PWR_RESET[PWR_LSB];
            ymin_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            sclk_d_reg <= sclk_d_next;
            cs_d_reg   <= cs_d_next;
            word_reg   <= word_next;
            fall_reg   <= fall_next;
            conv_reg   <= conv_next;
            convon_reg <= convon_next;
            res8c_reg  <= res8c_next;
            pwr_reg    <= pwr_next;
            adcup_reg  <= adcup_next;
            pen_en_reg <= pen_en_next;
            pull_reg   <= pull_next;
            ref_reg    <= ref_next;
            adc_reg    <= adc_next;
            ymin_reg   <= ymin_next;
        end
    end

    // Channel, resolution and reference fields update as bits arrive so switches can settle early; power field only at word end
    assign channel_select_o   = word_reg[CH_MSB:CH_LSB];  // R03
    assign res_8bit_o         = word_reg[RES_POS];        // R04
    assign reference_select_o = word_reg[REF_POS];        // R05 R20
    assign power_field_o      = pwr_reg;                  // R06
    assign ref_power_o        = ref_reg;
    assign adc_power_o        = adc_reg;
    assign conv_active_o      = convon_reg;
    assign yminus_switch_o    = ymin_reg;
    // Open-drain: only ever drives low
    assign touch_irq_n_o      = 1'b0;
    assign touch_irq_n_oe_o   = pull_reg;

    // Checks on the decoder
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_reset_power_field: assert property ( // R07
        !$past(resetn_i) |-> power_field_o == PWR_RESET)
        else $error("power field not at reset default");

    a_start_kills_pen: assert property ( // R22
        start_hit |=> !pen_en_reg ##1 !touch_irq_n_oe_o)
        else $error("pen interrupt still armed after start");

    a_idle_ignore_zero: assert property ( // R19
        state_reg == TACW_WAIT_START && !cs_n_s && sclk_rise && !din_s
        |=> state_reg == TACW_WAIT_START)
        else $error("zero bit opened a word");

    a_adc_wake_fourth: assert property ( // R17
        state_reg == TACW_SHIFT_WORD && !cs_n_s && sclk_fall &&
        fall_reg == FALL_ADC_UP - 1'b1 |=> ##1 adc_power_o)
        else $error("converter not awake at fourth fall");

    a_power_commit: assert property ( // R21
        word_done |=> power_field_o == $past(word_reg[PWR_MSB:PWR_LSB]))
        else $error("power bits not committed at word end");

    a_conv_end_sleep: assert property ( // R18
        conv_end && !pwr_reg[PWR_LSB] && state_reg == TACW_WAIT_START
        |=> ##1 !adc_power_o)
        else $error("converter awake after conversion end");

    a_cs_abort_sleep: assert property ( // R10
        cs_rise && !pwr_reg[PWR_LSB] |=> ##[0:1] !adc_power_o)
        else $error("converter awake after deselect");

    a_full_no_irq: assert property ( // R16
        pwr_reg == PWR_FULL && $stable(pwr_reg) |=> !pen_en_reg)
        else $error("pen interrupt armed in full power");

    a_lower_keeps_adc: assert property ( // R14
        pwr_reg[PWR_LSB] && $stable(pwr_reg) |=> adc_power_o)
        else $error("converter off with lower bit set");

    a_ref_independent: assert property ( // R09
        !pwr_reg[PWR_MSB] |-> !ref_power_o)
        else $error("reference on with upper bit clear");

    a_yminus_deep: assert property ( // R12
        pwr_reg == PWR_DEEP && !adc_power_o
        |-> yminus_switch_o)
        else $error("Y minus open in deep power-down");

    // The shadow restarts from a clean word at every start bit
    a_start_shadow: assert property ( // R01
        start_hit |=> word_reg == WORD_START)
        else $error("start bit did not open the word shadow");

    // Deselect always stops the conversion counter
    a_cs_ends_conv: assert property ( // R10
        cs_n_s && convon_reg |=> !conv_active_o)
        else $error("conversion kept running after deselect");

    // Pen comes back after a lone conversion unless fully powered
    a_conv_rearm: assert property ( // R15
        conv_end && state_reg == TACW_WAIT_START &&
        pwr_reg != PWR_FULL |=> pen_en_reg)
        else $error("pen interrupt not rearmed after conversion");

    // Counter never passes the length of the running conversion
    a_conv_span: assert property ( // R18
        convon_reg |-> conv_reg < (res8c_reg ? CONV_8B : CONV_12B))
        else $error("conversion ran past its length");

    // Reference power is never raised beyond the upper bit
    a_ref_tracks_upper: assert property ( // R13
        ref_power_o == power_field_o[PWR_MSB])
        else $error("reference power disagrees with upper bit");

endmodule // tacw_ctrl

//--- testbench/tacw_host.sv
// Purpose: Host serial master model for the control word pins.
// Assumes: Serial clock period 400 ns; it stands low between frames.
// Notes:   Data changes after each falling edge, as a real host does.
`timescale 1ns/1ns
module tacw_host (
    output logic serial_clock_o,  // Serial clock to device
    output logic serial_din_o,    // Serial data to device
    output logic cs_n_o           // Chip select, active low
);
    logic [31:0] bits_reg;        // Bits still to send, MSB first

    // Idle pins at time zero
    initial begin
        serial_clock_o = 1'b0;
        serial_din_o   = 1'b0;
        cs_n_o         = 1'b1;
        bits_reg       = 32'h0;
    end

    // Select device; odd offset keeps pin edges off the system clock
    task automatic start(input logic [31:0] b);
        bits_reg = b;
        #13 cs_n_o = 1'b0;
        #200;
    endtask

    // One bit per serial clock cycle; the first high bit is the start
    task automatic shift(input int n);
        for (int k = 0; k < n; k++) begin
            serial_din_o = bits_reg[31];
            bits_reg     = {bits_reg[30:0], 1'b0};
            #200 serial_clock_o = 1'b1;
            #200 serial_clock_o = 1'b0;
        end
    endtask

    // Deselect; data stops holding its last value so stale bits show
    task automatic stop();
        #100 cs_n_o = 1'b1;
        serial_din_o = ~serial_din_o;
    endtask
endmodule // tacw_host

//--- testbench/tb.sv
// Purpose: Self-checking bench for the control word and power decoder.
// Assumes: Host model paces frames; outputs settle within 8 sys cycles.
// Notes:   Frames are 24 serial clocks from the start bit, well above the minimum spacing; the abort frame is 12.
`timescale 1ns/1ns
module tb;
    import tacw_pkg::*;
    logic       clk_sys_i;        // System clock
    logic       resetn_i;         // Sync reset, active low
    logic       pen_touch_i;      // Touch stand-in
    logic       sclk;             // Serial clock from host
    logic       din;              // Serial data from host
    logic       cs_n;             // Chip select from host
    logic [2:0] chan;             // Channel selector
    logic       res8;             // 8-bit mode
    logic       refsel;           // Reference select
    logic [1:0] pwr;              // Power field
    logic       refp;             // Reference powered
    logic       adcp;             // Converter powered
    logic       conv;             // Conversion running
    logic       ym;               // Y minus switch
    logic       irq_d;            // Open-drain data
    logic       irq_oe;           // Open-drain enable
    wire        touch_irq_n;      // Pin level with pull-up
    int         bad_count;        // Mismatches
    int         tests_run;        // Comparisons made
    logic [1:0] pd;               // Power field under test
    logic [7:0] w;                // Word under test

    // Pull-up wins whenever the device lets go
    assign touch_irq_n = irq_oe ? irq_d : 1'b1;

    tacw_host tacw_host_i (.serial_clock_o(sclk), .serial_din_o(din),
                           .cs_n_o(cs_n));
    tacw_ctrl tacw_ctrl_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .serial_clock_i(sclk), .serial_din_i(din), .cs_n_i(cs_n),
        .pen_touch_i(pen_touch_i), .channel_select_o(chan),
        .res_8bit_o(res8), .reference_select_o(refsel),
        .power_field_o(pwr), .ref_power_o(refp), .adc_power_o(adcp),
        .conv_active_o(conv), .yminus_switch_o(ym),
        .touch_irq_n_o(irq_d), .touch_irq_n_oe_o(irq_oe));

    // 20 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // Value comparison, counted; mismatches reported at once
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    // Let synchroniser and edge logic catch up, then sample settled
    task automatic settle();
        repeat (8) @(posedge clk_sys_i);
        #1;
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard: a run this long counts as a failure
    initial begin
        #300000;
        bad_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        bad_count   = 0;
        tests_run   = 0;
        resetn_i    = 1'b0;
        pen_touch_i = 1'b1;
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        settle();
        // Power-up defaults, pen armed with touch present
        chk(pwr, 8'h02);
        chk(refp, 8'h01);
        chk(adcp, 8'h00);
        chk(touch_irq_n, 8'h00);
        $display("test reset ended");
        // Leading zeros, then channel 5, 12-bit, single-ended, field 00
        tacw_host_i.start({3'h0, 8'hd4, 21'h0});
        tacw_host_i.shift(3);
        settle();
        chk(chan, 8'h00);
        tacw_host_i.shift(3);
        settle();
        chk(touch_irq_n, 8'h01);
        chk(adcp, 8'h00);
        tacw_host_i.shift(1);
        settle();
        chk(adcp, 8'h01);
        chk(pwr, 8'h02);
        tacw_host_i.shift(4);
        settle();
        chk(pwr, 8'h00);
        chk(conv, 8'h01);
        tacw_host_i.shift(11);
        settle();
        chk(conv, 8'h01);
        tacw_host_i.shift(1);
        settle();
        chk(conv, 8'h00);
        chk(adcp, 8'h00);
        tacw_host_i.shift(4);
        tacw_host_i.stop();
        settle();
        chk(chan, 8'h05);
        chk(res8, 8'h00);
        chk(refsel, 8'h01);
        chk(refp, 8'h00);
        chk(ym, 8'h01);
        chk(touch_irq_n, 8'h00);
        // Touch lifted: armed pen must let the pin go high
        @(posedge clk_sys_i);
        pen_touch_i <= 1'b0;
        settle();
        chk(touch_irq_n, 8'h01);
        @(posedge clk_sys_i);
        pen_touch_i <= 1'b1;
        $display("test deep power down ended");
        // Remaining power fields in 8-bit mode; ref bit follows pd[1]
        for (int i = 1; i < 4; i++) begin
            pd = i[1:0];
            w  = {1'b1, 3'h3, 1'b1, pd[1], pd};
            tacw_host_i.start({w, 24'h0});
            tacw_host_i.shift(15);
            settle();
            chk(conv, 8'h01);
            tacw_host_i.shift(1);
            settle();
            chk(conv, 8'h00);
            tacw_host_i.shift(8); // 24 clocks per frame
            tacw_host_i.stop();
            settle();
            chk(res8, 8'h01);
            chk(refsel, {7'h0, pd[1]});
            chk(pwr, {6'h0, pd});
            chk(refp, {7'h0, pd[1]});
            chk(adcp, {7'h0, pd[0]});
            chk(ym, 8'h00);
            chk(touch_irq_n, {7'h0, pd == 2'h3});
        end
        $display("test power fields ended");
        // Mid-run reset from full power restores the defaults
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        settle();
        chk(pwr, 8'h02);
        chk(refp, 8'h01);
        chk(adcp, 8'h00);
        chk(touch_irq_n, 8'h00);
        $display("test mid-run reset ended");
        // Chip select rises mid-conversion with field 10
        tacw_host_i.start({8'h96, 24'h0});
        tacw_host_i.shift(12);
        tacw_host_i.stop();
        settle();
        chk(pwr, 8'h02);
        chk(conv, 8'h00);
        chk(adcp, 8'h00);
        chk(refp, 8'h01);
        chk(chan, 8'h01);
        $display("test abort ended");
        end_sim();
    end
endmodule // tb
